// *** rtl/eq_error_queue.sv ***
// Error queue with error classification, register file on APB and set point checks.
// Assumes pclk at 125 MHz, an APB master on pclk and a parser on pclk (no synchronisers).
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/100ps

module eq_error_queue
	import eq_pkg::*;
#(
	parameter int DEPTH = 16,
	parameter int STEP_DEPTH = 32,
	parameter logic [15:0] VALUE_MAX = 16'hea60
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire eq_parse_evt_t parse_evt,
	output logic [15:0] voltage_set,
	output logic [15:0] current_set,
	output logic trig_pulse,
	output logic queue_not_empty
);

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam int SW = $clog2(STEP_DEPTH + 1);
	localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
	localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);
	localparam logic [SW-1:0] STEP_FULL = SW'(STEP_DEPTH);

	// -------------------------------------------------------------
	// Register and queue state.
	// -------------------------------------------------------------
	eq_code_t q_mem [DEPTH];
	logic [AW-1:0] rd_ptr, wr_ptr, last_idx, wr_idx;
	logic [CW-1:0] count;
	logic [7:0] esr;
	logic [15:0] ovl, uvl, sel, cal_data;
	logic [3:0] mode;
	logic [SW-1:0] step_cnt;
	logic [7:0] addr;
	logic [16:0] rounded;
	eq_code_t apb_err_code, push_code, wr_data;
	// Strobes and status flags of the bus decode and of the queue's single write port.
	logic overflowed, rd_nonempty, acc_done, wr_done, rd_done, mapped, apb_err_valid;
	logic push_valid, do_cls, do_pop, q_full, wr_en;

	function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
		return (p == LAST_IDX) ? '0 : p + 1'b1;
	endfunction

	// Maps a code onto the status class bits that it sets.
	function automatic logic [7:0] class_bits(input eq_code_t c);
		logic [7:0] b;
		b = '0;
		b[EQ_ESR_CMD] = (c <= EQ_CMD_HI) && (c >= EQ_CMD_LO);
		b[EQ_ESR_EXE] = (c <= EQ_EXE_HI) && (c >= EQ_EXE_LO);
		b[EQ_ESR_DEV] = ((c <= EQ_DEV_HI) && (c >= EQ_DEV_LO)) || (c >= EQ_POS_LO);
		b[EQ_ESR_QRY] = (c <= EQ_QRY_HI) && (c >= EQ_QRY_LO);
		return b;
	endfunction

	// -------------------------------------------------------------
	// APB decode.
	// -------------------------------------------------------------
	// A parser event takes the single push slot, so every write, whether or not it could
	// queue an error, is held off for that cycle; reads go on and may pop meanwhile.
	assign pready = ~(parse_evt.valid & pwrite);
	assign acc_done = psel & penable & pready;
	assign addr = paddr[7:0];
	assign mapped = (paddr[31:8] == 24'h000000) && (addr[1:0] == 2'b00) && (addr <= EQ_A_SEL);
	assign wr_done = acc_done & pwrite & mapped;
	assign rd_done = acc_done & ~pwrite & mapped;
	assign pslverr = psel & penable & ~mapped;
	assign rounded = {1'b0, pwdata[EQ_VAL_MSB:EQ_VAL_LSB]} + {16'h0000, pwdata[EQ_VAL_HALF]};

	// Execution checks on register writes, set points and limits on the rounded value, SEL on raw pwdata; zero means accepted.
	always_comb
	begin
		apb_err_code = EQ_NO_ERR;
		case (addr)
			EQ_A_PUSH: apb_err_code = eq_code_t'(pwdata[15:0]);
			EQ_A_VSET:
			begin
				if (mode[EQ_MODE_ANALOG_V])
					apb_err_code = EQ_C_CONFLICT;
				else if (rounded > {1'b0, VALUE_MAX})
					apb_err_code = EQ_C_RANGE;
				else if (rounded > {1'b0, ovl} || rounded < {1'b0, uvl})
					apb_err_code = EQ_C_CONFLICT;
			end
			EQ_A_ISET:
			begin
				if (mode[EQ_MODE_ANALOG_I])
					apb_err_code = EQ_C_CONFLICT;
				else if (rounded > {1'b0, VALUE_MAX})
					apb_err_code = EQ_C_RANGE;
			end
			EQ_A_OVL, EQ_A_UVL:
			begin
				if (rounded > {1'b0, VALUE_MAX})
					apb_err_code = EQ_C_RANGE;
				else if ((addr == EQ_A_OVL) ? (rounded < {1'b0, voltage_set})
					: (rounded > {1'b0, voltage_set}))
					apb_err_code = EQ_C_CONFLICT;
			end
			EQ_A_TRIG:
			begin
				if (mode[EQ_MODE_PROG_RUN])
					apb_err_code = EQ_C_CONFLICT;
			end
			EQ_A_STEP:
			begin
				if (step_cnt == STEP_FULL)
					apb_err_code = EQ_C_NO_MEM;
			end
			EQ_A_CAL:
			begin
				if (mode[EQ_MODE_CAL_LOCK])
					apb_err_code = EQ_C_PROTECTED;
			end
			EQ_A_SEL:
			begin
				if (pwdata[15:0] > EQ_SEL_LAST)
					apb_err_code = EQ_C_ILLEGAL;
			end
			default: apb_err_code = EQ_NO_ERR;
		endcase
	end

	// A pushed code of zero still queues; other registers queue only a real fault.
	assign apb_err_valid = wr_done && ((addr == EQ_A_PUSH) || (apb_err_code != EQ_NO_ERR));

	// Parser faults map to fixed codes; pready keeps them apart from bus errors.
	always_comb
	begin
		push_valid = parse_evt.valid | apb_err_valid;
		push_code = apb_err_code;
		if (parse_evt.valid)
		begin
			unique case (parse_evt.kind)
				eq_perr_unrec_t_val: push_code = EQ_C_UNREC;
				eq_perr_too_many: push_code = EQ_C_TOO_MANY;
				eq_perr_too_few: push_code = EQ_C_TOO_FEW;
				eq_perr_undef_hdr: push_code = EQ_C_UNDEF_HDR;
				eq_perr_bad_num: push_code = EQ_C_BAD_NUM;
				eq_perr_bad_str: push_code = EQ_C_BAD_STR;
				default: push_code = EQ_C_UNREC;
			endcase
		end
	end

	// -------------------------------------------------------------
	// Queue.
	// -------------------------------------------------------------
	assign do_cls = wr_done & (addr == EQ_A_CTRL) & pwdata[EQ_CTRL_CLS];
	assign do_pop = rd_done & (addr == EQ_A_ERRQ) & rd_nonempty;
	assign q_full = (count == FULL_CNT);
	assign last_idx = (wr_ptr == '0) ? LAST_IDX : wr_ptr - 1'b1;
	assign queue_not_empty = (count != '0);

	// Write port; a full queue without a pop rewrites its newest entry.
	always_comb
	begin
		wr_en = push_valid;
		wr_data = push_code;
		wr_idx = do_cls ? '0 : wr_ptr;
		if (!do_cls && q_full && !do_pop)
		begin
			wr_idx = last_idx;
			wr_data = EQ_C_OVERFLOW;
		end
	end

	// Storage has no reset; only entries between the pointers are ever read.
	always_ff @(posedge pclk)
	begin
		if (wr_en)
			q_mem[wr_idx] <= wr_data;
	end

	// Pointers and fill level; a push into a full queue with a pop behaves normally.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rd_ptr <= '0;
			wr_ptr <= '0;
			count <= '0;
			overflowed <= 1'b0;
		end
		else if (do_cls)
		begin
			rd_ptr <= '0;
			wr_ptr <= push_valid ? AW'(1) : '0;
			count <= push_valid ? CW'(1) : '0;
			overflowed <= 1'b0;
		end
		else
		begin
			if (push_valid && !(q_full && !do_pop))
				wr_ptr <= ptr_inc(wr_ptr);
			if (do_pop)
				rd_ptr <= ptr_inc(rd_ptr);
			if (push_valid && !do_pop && !q_full)
				count <= count + 1'b1;
			else if (do_pop && !push_valid)
				count <= count - 1'b1;
			if (push_valid && q_full && !do_pop)
				overflowed <= 1'b1;
			else if (do_pop && count == CW'(1) && !push_valid)
				overflowed <= 1'b0;
		end
	end

	// Class bits are sticky; a new error outranks a clear in the same cycle.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			esr <= '0;
		end
		else
		begin
			esr <= ((do_cls || (wr_done && addr == EQ_A_ESR)) ? (esr & ~pwdata[7:0]
				| {8{~do_cls}} & esr & ~pwdata[7:0]) & {8{~do_cls}} : esr)
				| (push_valid ? class_bits(push_code) : 8'h00);
		end
	end

	// -------------------------------------------------------------
	// Set points, limits, mode and step buffer.
	// -------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			voltage_set <= EQ_RST_SET;
			current_set <= EQ_RST_SET;
			ovl <= EQ_RST_OVL;
			uvl <= EQ_RST_UVL;
			mode <= EQ_RST_MODE;
			sel <= '0;
			cal_data <= '0;
		end
		else if (wr_done && !apb_err_valid)
			case (addr)
				EQ_A_VSET: voltage_set <= rounded[15:0];
				EQ_A_ISET: current_set <= rounded[15:0];
				EQ_A_OVL: ovl <= rounded[15:0];
				EQ_A_UVL: uvl <= rounded[15:0];
				EQ_A_MODE: mode <= pwdata[3:0];
				EQ_A_SEL: sel <= pwdata[15:0];
				EQ_A_CAL: cal_data <= pwdata[15:0];
				default: sel <= sel;
			endcase
	end

	// Accepted triggers leave as one-cycle pulses; refused steps do not count.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			trig_pulse <= 1'b0;
			step_cnt <= '0;
		end
		else
		begin
			trig_pulse <= wr_done && addr == EQ_A_TRIG && !apb_err_valid;
			if (wr_done && addr == EQ_A_CTRL && pwdata[EQ_CTRL_STEP_CLR])
				step_cnt <= '0;
			else if (wr_done && addr == EQ_A_STEP && !apb_err_valid)
				step_cnt <= step_cnt + 1'b1;
		end
	end

	// -------------------------------------------------------------
	// Read data, captured in the setup cycle.
	// -------------------------------------------------------------
	// The head and its emptiness are latched together so that the popped entry
	// is always the one returned, even when a push lands between the setup and access cycles.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= '0;
			rd_nonempty <= 1'b0;
		end
		else if (psel && !penable)
		begin
			rd_nonempty <= queue_not_empty;
			case (addr)
				EQ_A_ERRQ: prdata <= queue_not_empty ? 32'(q_mem[rd_ptr]) : 32'(EQ_NO_ERR);
				EQ_A_ESR: prdata <= {24'h000000, esr};
				EQ_A_STAT: prdata <= {16'h0000, 7'(step_cnt), overflowed, 8'(count)};
				EQ_A_VSET: prdata <= {16'h0000, voltage_set};
				EQ_A_ISET: prdata <= {16'h0000, current_set};
				EQ_A_OVL: prdata <= {16'h0000, ovl};
				EQ_A_UVL: prdata <= {16'h0000, uvl};
				EQ_A_MODE: prdata <= {28'h0000000, mode};
				EQ_A_SEL: prdata <= {16'h0000, sel};
				EQ_A_CAL: prdata <= {16'h0000, cal_data};
				default: prdata <= '0;
			endcase
		end
	end

	// -------------------------------------------------------------
	// Assertions.
	// -------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_empty_read_zero: assert property (
		(psel && !penable && addr == EQ_A_ERRQ && count == '0) |=> prdata == 32'h00000000)
		else $error("empty queue query did not return zero");
	a_pop_order: assert property (
		(do_pop && !push_valid && !do_cls) |=> (count == $past(count) - 1'b1)
		&& (rd_ptr == ptr_inc($past(rd_ptr))))
		else $error("pop did not advance the queue by one");
	a_overflow_mark: assert property (
		(push_valid && q_full && !do_pop && !do_cls) |=> q_full
		&& q_mem[$past(last_idx)] == EQ_C_OVERFLOW && overflowed)
		else $error("overflow marker not written");
	a_cls_empty: assert property (
		(do_cls && !push_valid) |=> count == '0 ##1 !queue_not_empty || $past(push_valid))
		else $error("clear status left entries");
	a_push_pop_keep: assert property (
		(push_valid && do_pop && !do_cls) |=> count == $past(count))
		else $error("simultaneous push and pop changed the level");
	a_cmd_class: assert property (
		(push_valid && push_code <= EQ_CMD_HI && push_code >= EQ_CMD_LO) |=> esr[EQ_ESR_CMD])
		else $error("command class bit not set");
	a_exe_class: assert property (
		(push_valid && push_code <= EQ_EXE_HI && push_code >= EQ_EXE_LO) |=> esr[EQ_ESR_EXE])
		else $error("execution class bit not set");
	a_dev_class: assert property (
		(push_valid && push_code >= EQ_POS_LO) |=> esr[EQ_ESR_DEV])
		else $error("device class bit not set");
	a_qry_class: assert property (
		(push_valid && push_code <= EQ_QRY_HI && push_code >= EQ_QRY_LO) |=> esr[EQ_ESR_QRY])
		else $error("query class bit not set");
	a_analog_hold: assert property (
		(wr_done && addr == EQ_A_VSET && mode[EQ_MODE_ANALOG_V]) |=> $stable(voltage_set))
		else $error("set point changed under analog control");
	a_step_full: assert property (
		(wr_done && addr == EQ_A_STEP && step_cnt == STEP_FULL) |-> push_code == EQ_C_NO_MEM)
		else $error("full step buffer not reported");
	a_cal_lock: assert property (
		(wr_done && addr == EQ_A_CAL && mode[EQ_MODE_CAL_LOCK]) |=> $stable(cal_data))
		else $error("protected write went through");

	c_overflow: cover property (push_valid && q_full && !do_pop);
	c_drain: cover property (do_pop && count == CW'(1) ##2 psel && !penable && addr == EQ_A_ERRQ);
	c_push_pop: cover property (push_valid && do_pop);
	c_cls: cover property (do_cls && queue_not_empty);

endmodule

// *** rtl/eq_pkg.sv ***
// Package of the error queue block: register map, field positions, error codes, types.
// Assumes a 32-bit APB master on the same clock and a parser that reports one event per cycle.
package eq_pkg;

	// Error codes held in the queue are 16-bit two's complement numbers.
	typedef logic signed [15:0] eq_code_t;

	// Kinds of syntax fault that the command parser reports.
	typedef enum logic [2:0] {
		eq_perr_unrec_t_val = 3'b000,
		eq_perr_too_many = 3'b001,
		eq_perr_too_few = 3'b010,
		eq_perr_undef_hdr = 3'b011,
		eq_perr_bad_num = 3'b100,
		eq_perr_bad_str = 3'b101
	} eq_perr_t;

	// One parser event: a valid strobe with the kind of fault.
	typedef struct packed {
		logic valid;
		eq_perr_t kind;
	} eq_parse_evt_t;

	// -------------------------------------------------------------
	// Register byte offsets.
	// -------------------------------------------------------------
	localparam logic [7:0] EQ_A_CTRL = 8'h00;
	localparam logic [7:0] EQ_A_ERRQ = 8'h04;
	localparam logic [7:0] EQ_A_ESR = 8'h08;
	localparam logic [7:0] EQ_A_STAT = 8'h0c;
	localparam logic [7:0] EQ_A_PUSH = 8'h10;
	localparam logic [7:0] EQ_A_VSET = 8'h14;
	localparam logic [7:0] EQ_A_ISET = 8'h18;
	localparam logic [7:0] EQ_A_OVL = 8'h1c;
	localparam logic [7:0] EQ_A_UVL = 8'h20;
	localparam logic [7:0] EQ_A_MODE = 8'h24;
	localparam logic [7:0] EQ_A_TRIG = 8'h28;
	localparam logic [7:0] EQ_A_STEP = 8'h2c;
	localparam logic [7:0] EQ_A_CAL = 8'h30;
	localparam logic [7:0] EQ_A_SEL = 8'h34;

	// -------------------------------------------------------------
	// Field positions and reset values.
	// -------------------------------------------------------------
	localparam int EQ_CTRL_CLS = 0;
	localparam int EQ_CTRL_STEP_CLR = 1;
	localparam int EQ_MODE_CAL_LOCK = 0;
	localparam int EQ_MODE_ANALOG_V = 1;
	localparam int EQ_MODE_ANALOG_I = 2;
	localparam int EQ_MODE_PROG_RUN = 3;
	localparam int EQ_ESR_CMD = 5;
	localparam int EQ_ESR_EXE = 4;
	localparam int EQ_ESR_DEV = 3;
	localparam int EQ_ESR_QRY = 2;
	localparam int EQ_VAL_LSB = 4;
	localparam int EQ_VAL_MSB = 19;
	localparam int EQ_VAL_HALF = 3;
	localparam logic [15:0] EQ_RST_OVL = 16'hffff;
	localparam logic [15:0] EQ_RST_UVL = 16'h0000;
	localparam logic [15:0] EQ_RST_SET = 16'h0000;
	localparam logic [3:0] EQ_RST_MODE = 4'h1;
	localparam logic [15:0] EQ_SEL_LAST = 16'h0002;

	// -------------------------------------------------------------
	// Error codes and class boundaries.
	// -------------------------------------------------------------
	localparam eq_code_t EQ_NO_ERR = 16'sd0;
	localparam eq_code_t EQ_C_UNREC = -16'sd102;
	localparam eq_code_t EQ_C_TOO_MANY = -16'sd108;
	localparam eq_code_t EQ_C_TOO_FEW = -16'sd109;
	localparam eq_code_t EQ_C_UNDEF_HDR = -16'sd113;
	localparam eq_code_t EQ_C_BAD_NUM = -16'sd121;
	localparam eq_code_t EQ_C_BAD_STR = -16'sd151;
	localparam eq_code_t EQ_C_PROTECTED = -16'sd203;
	localparam eq_code_t EQ_C_CONFLICT = -16'sd221;
	localparam eq_code_t EQ_C_RANGE = -16'sd222;
	localparam eq_code_t EQ_C_ILLEGAL = -16'sd224;
	localparam eq_code_t EQ_C_NO_MEM = -16'sd291;
	localparam eq_code_t EQ_C_OVERFLOW = -16'sd350;
	localparam eq_code_t EQ_CMD_HI = -16'sd100;
	localparam eq_code_t EQ_CMD_LO = -16'sd199;
	localparam eq_code_t EQ_EXE_HI = -16'sd200;
	localparam eq_code_t EQ_EXE_LO = -16'sd299;
	localparam eq_code_t EQ_DEV_HI = -16'sd300;
	localparam eq_code_t EQ_DEV_LO = -16'sd399;
	localparam eq_code_t EQ_QRY_HI = -16'sd400;
	localparam eq_code_t EQ_QRY_LO = -16'sd499;
	localparam eq_code_t EQ_POS_LO = 16'sd1;

endpackage

// *** verif/eq_host_model.sv ***
// APB master standing in for the remote host that reads and writes the error queue block.
// Assumes the slave samples on pclk and that the bench issues one transfer at a time.
`timescale 1ns/100ps
module eq_host_model
(
	input wire logic pclk,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [31:0] paddr,
	output logic [31:0] pwdata,
	output logic err
);
	// The bus is idle at time zero, so no transfer can start before reset is released.
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0;
		pwdata = 32'h0;
		err = 1'b0;
	end

	// One transfer: setup cycle, then access held until pready is sampled high.
	// Write data is inverted on release so a slave that samples late sees garbage.
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {24'h0, a};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~d;
	endtask
endmodule

// *** verif/test_error_queue_reporting.sv ***
// Self-checking bench for the error queue block, driven through its APB port and parser port.
// Assumes a small queue and step buffer so overflow and buffer-full cases are reached quickly.
`timescale 1ns/100ps
module test_error_queue_reporting
	import eq_pkg::*;
;
	localparam int DQ = 8;
	localparam int DS = 4;
	localparam logic [15:0] VMAX = 16'hea60;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	eq_parse_evt_t parse_evt = '0;
	logic psel, penable, pwrite, pready, pslverr, trig_pulse, queue_not_empty, host_err;
	logic [31:0] paddr, pwdata, prdata;
	logic [15:0] voltage_set, current_set;
	int fails = 0;
	int samples_checked = 0;
	eq_code_t kc[6] = '{EQ_C_UNREC, EQ_C_TOO_MANY, EQ_C_TOO_FEW, EQ_C_UNDEF_HDR,
		EQ_C_BAD_NUM, EQ_C_BAD_STR};
	eq_code_t cls[4] = '{EQ_EXE_HI, EQ_DEV_HI, EQ_QRY_HI, EQ_POS_LO};

	// Free-running 125 MHz clock.
	always #4 pclk = ~pclk;

	eq_error_queue #(.DEPTH(DQ), .STEP_DEPTH(DS), .VALUE_MAX(VMAX)) DUT (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.parse_evt(parse_evt), .voltage_set(voltage_set), .current_set(current_set),
		.trig_pulse(trig_pulse), .queue_not_empty(queue_not_empty));

	eq_host_model host (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.err(host_err));

	// ---------------------------------------------------------------
	// Shared tasks.
	// ---------------------------------------------------------------
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e)
		begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic chk_rd(input string n, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		host.xfer(1'b0, a, 32'h0, q);
		chk(n, e, q);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		host.xfer(1'b1, a, d, q);
	endtask

	// A parser fault is a one-cycle strobe; the bus is idle meanwhile except in t_pushpop, where a read overlaps it.
	task automatic evt(input eq_perr_t k);
		@(posedge pclk);
		parse_evt <= {1'b1, k};
		@(posedge pclk);
		parse_evt <= '0;
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ---------------------------------------------------------------
	// Scenarios.
	// ---------------------------------------------------------------
	task automatic t_reset();
		logic [31:0] q;
		chk_rd("empty", EQ_A_ERRQ, 32'h0);
		chk_rd("mode", EQ_A_MODE, {28'h0, EQ_RST_MODE});
		chk_rd("ovl", EQ_A_OVL, {16'h0, EQ_RST_OVL});
		host.xfer(1'b0, 8'h40, 32'h0, q);
		chk("unmapped", 32'h0, q);
		chk("slverr", 32'h1, {31'h0, host_err});
		$display("test reset done");
	endtask

	task automatic t_parse();
		for (int i = 0; i < 6; i++)
			evt(eq_perr_t'(i));
		chk_rd("esr", EQ_A_ESR, 32'h20);
		chk("nonempty", 32'h1, {31'h0, queue_not_empty});
		for (int i = 0; i < 6; i++)
			chk_rd("errq", EQ_A_ERRQ, 32'(kc[i]));
		chk_rd("stat", EQ_A_STAT, 32'h0);
		chk_rd("drained", EQ_A_ERRQ, 32'h0);
		chk("empty_flag", 32'h0, {31'h0, queue_not_empty});
		wr(EQ_A_ESR, 32'h3c);
		$display("test parse done");
	endtask

	// The lost code still marks its class even though -350 takes its place.
	task automatic t_overflow();
		for (int i = 0; i < DQ; i++)
			wr(EQ_A_PUSH, {16'h0, cls[i % 4]});
		wr(EQ_A_PUSH, {16'h0, EQ_C_BAD_STR});
		chk_rd("stat", EQ_A_STAT, 32'h100 | DQ);
		chk_rd("esr", EQ_A_ESR, 32'h3c);
		for (int i = 0; i < DQ - 1; i++)
			chk_rd("errq", EQ_A_ERRQ, 32'(cls[i % 4]));
		chk_rd("marker", EQ_A_ERRQ, 32'(EQ_C_OVERFLOW));
		chk_rd("drained", EQ_A_ERRQ, 32'h0);
		$display("test overflow done");
	endtask

	task automatic t_clear();
		wr(EQ_A_PUSH, 32'h5);
		wr(EQ_A_CTRL, 32'h1);
		chk_rd("stat", EQ_A_STAT, 32'h0);
		chk_rd("errq", EQ_A_ERRQ, 32'h0);
		chk_rd("esr", EQ_A_ESR, 32'h0);
		$display("test clear done");
	endtask

	// Refused writes in a row; a value that only rounding pushes past the limit is refused.
	task automatic t_exec();
		eq_code_t ex[7] = '{EQ_C_PROTECTED, EQ_C_ILLEGAL, EQ_C_RANGE, EQ_C_CONFLICT,
			EQ_C_CONFLICT, EQ_C_CONFLICT, EQ_C_NO_MEM};
		wr(EQ_A_CAL, 32'h1);
		wr(EQ_A_SEL, 32'h3);
		wr(EQ_A_VSET, {12'h0, 16'h0010, 4'h8});
		@(negedge pclk);
		chk("vset", 32'h11, {16'h0, voltage_set});
		wr(EQ_A_VSET, {12'h0, VMAX, 4'h8});
		@(negedge pclk);
		chk("vkeep", 32'h11, {16'h0, voltage_set});
		wr(EQ_A_OVL, {12'h0, 16'h0010, 4'h0});
		wr(EQ_A_MODE, 32'h2);
		wr(EQ_A_VSET, {12'h0, 16'h0005, 4'h0});
		wr(EQ_A_MODE, 32'h8);
		wr(EQ_A_TRIG, 32'h1);
		for (int i = 0; i <= DS; i++)
			wr(EQ_A_STEP, 32'h1);
		chk_rd("esr", EQ_A_ESR, 32'h10);
		for (int i = 0; i < 7; i++)
			chk_rd("errq", EQ_A_ERRQ, 32'(ex[i]));
		chk_rd("drained", EQ_A_ERRQ, 32'h0);
		wr(EQ_A_MODE, 32'h0);
		wr(EQ_A_TRIG, 32'h1);
		#1;
		chk("trig", 32'h1, {31'h0, trig_pulse});
		wr(EQ_A_ISET, {12'h0, 16'h0020, 4'h7});
		@(negedge pclk);
		chk("iset", 32'h20, {16'h0, current_set});
		wr(EQ_A_MODE, 32'h4);
		wr(EQ_A_ISET, {12'h0, 16'h0030, 4'h0});
		wr(EQ_A_OVL, {12'h0, 16'h0030, 4'h0});
		wr(EQ_A_VSET, {12'h0, 16'h0040, 4'h0});
		wr(EQ_A_UVL, {12'h0, 16'h0020, 4'h0});
		@(negedge pclk);
		chk("ikeep", 32'h20, {16'h0, current_set});
		for (int i = 0; i < 3; i++)
			chk_rd("conflict", EQ_A_ERRQ, 32'(EQ_C_CONFLICT));
		chk_rd("steps", EQ_A_STAT, 32'h800);
		wr(EQ_A_CTRL, 32'h2);
		chk_rd("stepclr", EQ_A_STAT, 32'h0);
		$display("test exec done");
	endtask

	// A fault arrives while a full queue is popped: the head leaves, the fault takes its slot.
	task automatic t_pushpop();
		for (int i = 0; i < DQ; i++)
			wr(EQ_A_PUSH, 32'(i + 1));
		fork
			chk_rd("head", EQ_A_ERRQ, 32'h1);
			begin
				@(posedge pclk);
				evt(eq_perr_too_few);
			end
		join
		chk_rd("level", EQ_A_STAT, 32'(DQ));
		for (int i = 1; i < DQ; i++)
			chk_rd("errq", EQ_A_ERRQ, 32'(i + 1));
		chk_rd("pushed", EQ_A_ERRQ, 32'(EQ_C_TOO_FEW));
		chk_rd("drained", EQ_A_ERRQ, 32'h0);
		$display("test push pop done");
	endtask

	// Main sequence: reset for five cycles, then every scenario in turn.
	initial
	begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_parse();
		t_overflow();
		t_clear();
		t_exec();
		t_pushpop();
		close_out();
	end

	// Watchdog: the scenarios need well under 1000 cycles.
	initial
	begin
		#40000;
		fails++;
		close_out();
	end
endmodule
